// file: rtl/dolc_top.sv
// Deserializer output, lock and recovered-clock control with AXI4-Lite.
// Assumes serial bits arrive one per aclk, synchronous to aclk.
// Functional notes
// (RQ1) Edge select picks rising or falling strobe
// (RQ2) Power-down halts recovery, floats all outputs
// (RQ3) Lock indicator low when locked, else high
// (RQ4) Output enable low floats data, lock, clock
// (RQ5) Not locked floats data and recovered clock
// (RQ6) Enabled and locked drives data, clock toggles
// (RQ7) Recovered clock runs at word rate
// (RQ8) Lock indicator reports lock state continuously
// (RQ9) System supplies running local reference clock
// (RQ10) Loss declared after four bad word periods
// (RQ11) Serializer sends sync while requested
// (RQ12) One stable word per recovered clock period
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "dolc_cfg.svh"

module dolc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`DOLC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`DOLC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in_pos,
  input wire logic serial_in_neg,
  input wire logic local_reference_clock,
  output logic [`DOLC_WORD_W-1:0] parallel_word_out,
  output logic parallel_word_out_oe,
  output logic recovered_clock,
  output logic recovered_clock_oe,
  output logic lock_n,
  output logic lock_n_oe
);

  // Frame check shared by hunting, checking and locked tracking
  function automatic logic frame_ok(input logic [11:0] sh, input logic err);
    frame_ok = sh[11] && !sh[0] && !err;
  endfunction

  dolc_pkg::dolc_state_t state_q;
  logic [2:0] ctrl_q;
  logic ovf_q;
  logic loss_q;
  logic [11:0] sh_q;
  logic [11:0] sh_d;
  logic err_q;
  logic [`DOLC_CNT_W-1:0] bit_q;
  logic [2:0] bad_q;
  logic ref_prev_q;
  logic [7:0] ref_cnt_q;
  logic ref_ok;
  logic bit_val;
  logic bit_bad;
  logic frame_end;
  logic good;
  logic locked;
  logic powered;
  logic enabled;
  logic drive;
  logic strobe_pt;
  logic push_word;
  logic rclk_q;
  dolc_pkg::dolc_word_t word_q;

  dolc_fifo_if #(.WIDTH(`DOLC_WORD_W), .LVL_W(`DOLC_FIFO_LVL_W)) fif ();

  dolc_fifo #(
    .WIDTH(`DOLC_WORD_W),
    .DEPTH(`DOLC_FIFO_DEPTH),
    .LVL_W(`DOLC_FIFO_LVL_W)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(fif.store)
  );

  assign powered = ctrl_q[`DOLC_CTRL_PWR_N];
  assign enabled = !ctrl_q[`DOLC_CTRL_OE_N];
  assign locked = (state_q == dolc_pkg::DOLC_ST_LOCK);

  // Differential pair with equal legs carries no valid bit
  assign bit_val = serial_in_pos;
  assign bit_bad = (serial_in_pos == serial_in_neg);
  assign sh_d = {sh_q[10:0], bit_val};
  assign frame_end = (bit_q == `DOLC_LAST_BIT);
  assign good = frame_ok(sh_d, err_q || bit_bad);

  // Reference clock watchdog; recovery waits for a running reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev_q <= 1'b0;
      ref_cnt_q <= 8'h00;
    end else begin
      ref_prev_q <= local_reference_clock;
      if (ref_prev_q != local_reference_clock) begin
        ref_cnt_q <= 8'h00; // RQ9
      end else if (ref_cnt_q != `DOLC_REF_TIMEOUT) begin
        ref_cnt_q <= ref_cnt_q + 8'h01;
      end
    end
  end
  assign ref_ok = (ref_cnt_q != `DOLC_REF_TIMEOUT);

  // Serial shift and bit position within the word period
  always_ff @(posedge aclk) begin
    if (!aresetn || !powered) begin
      sh_q <= 12'h000;
      err_q <= 1'b0;
      bit_q <= 4'h0;
    end else begin
      sh_q <= sh_d;
      if (state_q == dolc_pkg::DOLC_ST_HUNT && good) begin
        bit_q <= 4'h0;
        err_q <= 1'b0;
      end else if (frame_end) begin
        bit_q <= 4'h0;
        err_q <= 1'b0;
      end else begin
        bit_q <= bit_q + 4'h1;
        err_q <= err_q || bit_bad;
      end
    end
  end

  // Lock state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= dolc_pkg::DOLC_ST_DOWN;
      bad_q <= 3'h0;
    end else if (!powered || !ref_ok) begin
      state_q <= dolc_pkg::DOLC_ST_DOWN; // RQ2
      bad_q <= 3'h0;
    end else begin
      case (state_q)
        dolc_pkg::DOLC_ST_DOWN: begin
          state_q <= dolc_pkg::DOLC_ST_HUNT;
        end
        dolc_pkg::DOLC_ST_HUNT: begin
          if (good) begin
            state_q <= dolc_pkg::DOLC_ST_CHECK;
          end
        end
        dolc_pkg::DOLC_ST_CHECK: begin
          if (frame_end) begin
            state_q <= good ? dolc_pkg::DOLC_ST_LOCK : dolc_pkg::DOLC_ST_HUNT;
            bad_q <= 3'h0;
          end
        end
        dolc_pkg::DOLC_ST_LOCK: begin
          if (frame_end) begin
            if (good) begin
              bad_q <= 3'h0;
            end else if (bad_q + 3'h1 == `DOLC_LOSS_LIMIT) begin
              state_q <= dolc_pkg::DOLC_ST_HUNT; // RQ10
              bad_q <= 3'h0;
            end else begin
              bad_q <= bad_q + 3'h1; // RQ10
            end
          end
        end
        default: begin
          state_q <= dolc_pkg::DOLC_ST_DOWN;
        end
      endcase
    end
  end

  // Words of bad periods still go out, as a real part would deliver them
  assign push_word = locked && frame_end;
  assign fif.push_valid = push_word;
  assign fif.push_data = sh_d[10:1];

  // Output side: strobe point sits half a period from data change
  assign drive = powered && enabled && locked;
  assign strobe_pt = ctrl_q[`DOLC_CTRL_EDGE] ? (bit_q == `DOLC_HALF_BIT)
                                             : (bit_q == 4'h0); // RQ1
  assign fif.pop_ready = drive && strobe_pt; // RQ12

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_q <= 10'h000;
    end else if (fif.pop_valid && fif.pop_ready) begin
      word_q <= fif.pop_data; // RQ12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !drive) begin
      rclk_q <= 1'b0; // RQ6
    end else begin
      rclk_q <= (bit_q < `DOLC_HALF_BIT); // RQ7
    end
  end

  assign parallel_word_out = word_q;
  assign recovered_clock = rclk_q;
  assign parallel_word_out_oe = drive; // RQ4 RQ5
  assign recovered_clock_oe = drive; // RQ5 RQ6
  assign lock_n = !locked; // RQ3
  assign lock_n_oe = powered && enabled; // RQ2 RQ8

  // Sticky status events; an event wins over a same-cycle clear
  logic wr_go;
  logic st_clr;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_go = s_axi_awready;
  assign st_clr = wr_go && s_axi_wstrb[0] &&
                  (s_axi_awaddr == `DOLC_OFF_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_q <= 1'b0;
    end else if (push_word && !fif.push_ready) begin
      ovf_q <= 1'b1;
    end else if (st_clr && s_axi_wdata[`DOLC_ST_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loss_q <= 1'b0;
    end else if (locked && frame_end && !good &&
                 bad_q + 3'h1 == `DOLC_LOSS_LIMIT) begin
      loss_q <= 1'b1;
    end else if (st_clr && s_axi_wdata[`DOLC_ST_LOSS]) begin
      loss_q <= 1'b0;
    end
  end

  // Control register; power-down doubles as the core reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `DOLC_CTRL_RESET;
    end else if (wr_go && s_axi_wstrb[0] &&
                 s_axi_awaddr == `DOLC_OFF_CTRL) begin
      ctrl_q <= s_axi_wdata[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DOLC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr == `DOLC_OFF_CTRL ||
                      s_axi_awaddr == `DOLC_OFF_STATUS) ?
                     `DOLC_RESP_OKAY : `DOLC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read side
  logic [31:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `DOLC_OFF_CTRL: begin
        rd_val[2:0] = ctrl_q;
      end
      `DOLC_OFF_STATUS: begin
        rd_val[`DOLC_ST_LOCKED] = locked;
        rd_val[`DOLC_ST_FULL] = !fif.push_ready;
        rd_val[`DOLC_ST_OVF] = ovf_q;
        rd_val[`DOLC_ST_LOSS] = loss_q;
        rd_val[`DOLC_ST_REF_OK] = ref_ok;
        rd_val[`DOLC_ST_LVL_LSB +: `DOLC_FIFO_LVL_W] = fif.level;
      end
      `DOLC_OFF_WORD: begin
        rd_val[`DOLC_WORD_W-1:0] = word_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DOLC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? `DOLC_RESP_OKAY : `DOLC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: rtl/dolc_cfg.svh
// Constants for the deserializer output and lock control block.
// Assumes a 100 MHz aclk and one serial bit sampled per aclk cycle.
`ifndef DOLC_CFG_SVH
`define DOLC_CFG_SVH

`define DOLC_WORD_W 10
`define DOLC_FRAME_LEN 12
`define DOLC_CNT_W 4
`define DOLC_LAST_BIT 4'hB
`define DOLC_HALF_BIT 4'h6
`define DOLC_LOSS_LIMIT 3'h4
`define DOLC_FIFO_DEPTH 8
`define DOLC_FIFO_LVL_W 4
`define DOLC_REF_TIMEOUT 8'h40
`define DOLC_ADDR_W 8

`define DOLC_OFF_CTRL 8'h00
`define DOLC_OFF_STATUS 8'h04
`define DOLC_OFF_WORD 8'h08

`define DOLC_CTRL_PWR_N 0
`define DOLC_CTRL_OE_N 1
`define DOLC_CTRL_EDGE 2
`define DOLC_CTRL_RESET 3'h2

`define DOLC_ST_LOCKED 0
`define DOLC_ST_FULL 1
`define DOLC_ST_OVF 2
`define DOLC_ST_LOSS 3
`define DOLC_ST_REF_OK 4
`define DOLC_ST_LVL_LSB 8

`define DOLC_RESP_OKAY 2'h0
`define DOLC_RESP_SLVERR 2'h2

`endif

// file: rtl/dolc_pkg.sv
// Types for the deserializer output and lock control block.
// Assumes dolc_cfg.svh supplies the numeric constants.
package dolc_pkg;

  typedef enum logic [1:0] {
    DOLC_ST_DOWN = 2'b00,
    DOLC_ST_HUNT = 2'b01,
    DOLC_ST_CHECK = 2'b10,
    DOLC_ST_LOCK = 2'b11
  } dolc_state_t;

  typedef logic [9:0] dolc_word_t;

endpackage

// file: rtl/dolc_fifo_if.sv
// Carrier between the word FIFO and the lock control core.
// Assumes both ends share aclk.
`timescale 1ns/100ps
`default_nettype none

interface dolc_fifo_if #(
  parameter int WIDTH = 10,
  parameter int LVL_W = 4
);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic [LVL_W-1:0] level;

  modport store (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data, level
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data, level
  );
endinterface

`default_nettype wire

// file: rtl/dolc_fifo.sv
// Synchronous word FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module dolc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8,
  parameter int LVL_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  dolc_fifo_if.store port
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [LVL_W-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign port.push_ready = (cnt_q != LVL_W'(DEPTH));
  assign port.pop_valid = (cnt_q != '0);
  assign port.pop_data = mem_q[rd_q];
  assign port.level = cnt_q;
  assign do_push = port.push_valid && port.push_ready;
  assign do_pop = port.pop_valid && port.pop_ready;

  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem_q[wr_q] <= port.push_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == PTR_W'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (do_push && !do_pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (do_pop && !do_push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

`default_nettype wire

// file: testbench/dolc_checker.sv
// Checker for dolc_top output enables, lock and recovered clock.
// Assumes one clock aclk and a synchronous active-low aresetn.
`timescale 1ns/100ps
`default_nettype none
module dolc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic [9:0] parallel_word_out,
  input wire logic parallel_word_out_oe,
  input wire logic recovered_clock,
  input wire logic recovered_clock_oe,
  input wire logic lock_n,
  input wire logic lock_n_oe
);
  logic rc_q;
  logic oe_q;
  logic [3:0] run_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) rc_q <= recovered_clock;
  always_ff @(posedge aclk) oe_q <= parallel_word_out_oe;
  // Counter instead of a long repetition; restarts once drive is settled
  always_ff @(posedge aclk) begin
    if (!aresetn || !oe_q || !parallel_word_out_oe ||
        rc_q != recovered_clock) begin
      run_q <= 4'h0;
    end else begin
      run_q <= run_q + 4'h1;
    end
  end
  property p_oe_pair;
    recovered_clock_oe == parallel_word_out_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
  property p_unlock_float;
    lock_n |-> !parallel_word_out_oe;
  endproperty
  a_unlock_float: assert property (p_unlock_float) else $error("drives unlocked");
  property p_float_all;
    !lock_n_oe |-> !parallel_word_out_oe;
  endproperty
  a_float_all: assert property (p_float_all) else $error("data without lock");
  property p_rclk_run;
    run_q < 4'h6;
  endproperty
  a_rclk_run: assert property (p_rclk_run) else $error("clock stalled");
  property p_rclk_rate;
    $rose(recovered_clock) && parallel_word_out_oe
      |-> ##12 ($rose(recovered_clock) || !parallel_word_out_oe);
  endproperty
  a_rclk_rate: assert property (p_rclk_rate) else $error("clock period");
  property p_word_edge;
    $changed(parallel_word_out) && parallel_word_out_oe && $past(parallel_word_out_oe)
      |-> (recovered_clock != $past(recovered_clock, 2))
        or (##1 $changed(recovered_clock));
  endproperty
  a_word_edge: assert property (p_word_edge) else $error("word off edge");
  property p_lock_oe_cause;
    $changed(lock_n_oe) |-> $rose(s_axi_bvalid);
  endproperty
  a_lock_oe_cause: assert property (p_lock_oe_cause) else $error("lock float");
  property p_drive_cause;
    $rose(parallel_word_out_oe) |-> $fell(lock_n) || $rose(s_axi_bvalid);
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("drive cause");
  cover property (!lock_n && parallel_word_out_oe);
  cover property ($rose(lock_n));
  cover property ($rose(recovered_clock_oe));
endmodule
bind dolc_top dolc_checker u_chk (.aclk, .aresetn, .s_axi_bvalid,
  .parallel_word_out, .parallel_word_out_oe, .recovered_clock,
  .recovered_clock_oe, .lock_n, .lock_n_oe);
`default_nettype wire

// file: testbench/dolc_ser_model.sv
// Serializer model: one framed bit per aclk on the serial pair.
// Assumes the bench supplies words and a corrupt request.
`timescale 1ns/100ps
`default_nettype none
module dolc_ser_model #(
  parameter logic [9:0] SYNC_WORD = 10'h3E0
) (
  input wire logic aclk,
  input wire logic sync_request_a,
  input wire logic sync_request_b,
  input wire logic corrupt,
  input wire logic [9:0] next_word,
  output logic word_taken = 1'h0,
  output logic serial_in_pos = 1'h0,
  output logic serial_in_neg = 1'h1
);
  logic [3:0] bit_q = 4'h0;
  logic [11:0] frame_q = 12'h0;
  always @(posedge aclk) begin
    logic [11:0] f;
    logic s;
    s = sync_request_a || sync_request_b;
    f = frame_q;
    if (bit_q == 4'h0) begin
      f = s ? {1'h1, SYNC_WORD, 1'h0} : {1'h1, next_word, 1'h0};
    end
    word_taken <= (bit_q == 4'h0) && !s;
    serial_in_pos <= f[11];
    // Equal halves mark an invalid bit
    serial_in_neg <= corrupt ? f[11] : !f[11];
    frame_q <= f << 1;
    bit_q <= (bit_q == 4'hB) ? 4'h0 : bit_q + 4'h1;
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Bench for dolc_top: register bus master, serializer, word scoreboard.
// Assumes the checker and serializer model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [9:0] SYNC = 10'h3E0;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [9:0] parallel_word_out, next_word = 10'h155;
  logic parallel_word_out_oe, recovered_clock, recovered_clock_oe;
  logic lock_n, lock_n_oe, serial_in_pos, serial_in_neg, taken;
  logic corrupt = 1'h0, sync_b = 1'h0, mon_on = 1'h0, edge_sel = 1'h1;
  logic rc_prev = 1'h0, lock_last = 1'h0;
  logic [2:0] ref_div = 3'h0;
  logic [31:0] seed = 32'h4C;
  logic [9:0] exp_q[$];
  int err_total = 0, total_checks = 0, cyc = 0;
  dolc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_in_pos, .serial_in_neg, .local_reference_clock(ref_div[2]),
    .parallel_word_out, .parallel_word_out_oe, .recovered_clock,
    .recovered_clock_oe, .lock_n, .lock_n_oe);
  // Released lock pin shows the inverse of its last driven level
  dolc_ser_model u_ser (.aclk,
    .sync_request_a(lock_n_oe ? lock_n : !lock_last), .sync_request_b(sync_b),
    .corrupt, .next_word, .word_taken(taken), .serial_in_pos, .serial_in_neg);
  always #5 aclk = !aclk;
  function automatic logic [9:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    // Sync and reset values are filtered out, so never send them as data
    return (seed[9:0] == SYNC || seed[9:0] == 10'h000) ? 10'h001 : seed[9:0];
  endfunction
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD at %0t expected %h got %h", $time, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Driver: sends words and notes each one expected
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ref_div <= ref_div + 3'h1;
    if (lock_n_oe === 1'h1) lock_last <= lock_n;
    if (taken) begin
      exp_q.push_back(next_word);
      next_word <= rnd();
    end
    if (cyc == 12000) begin
      err_total++;
      end_of_test();
    end
  end
  // Monitor: word sampled at the selected strobe edge
  // Reset word stands until the first pop after lock, so it is skipped
  always @(posedge aclk) begin
    rc_prev <= recovered_clock;
    if (mon_on && parallel_word_out_oe === 1'h1 && recovered_clock !== rc_prev
        && recovered_clock === edge_sel && parallel_word_out !== SYNC
        && parallel_word_out !== 10'h000) begin
      check(exp_q.size() ? 32'(exp_q.pop_front()) : 32'hFFFFFFFF,
        32'(parallel_word_out));
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    @(negedge aclk);
    while (s_axi_awready !== 1'h1) @(negedge aclk);
    @(posedge aclk);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    @(negedge aclk);
    while (s_axi_bvalid !== 1'h1) @(negedge aclk);
    check(32'(r), 32'(s_axi_bresp));
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    @(negedge aclk);
    while (s_axi_arready !== 1'h1) @(negedge aclk);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    @(negedge aclk);
    while (s_axi_rvalid !== 1'h1) @(negedge aclk);
    check(e, s_axi_rdata & m);
    check((a > 8'h08) ? 32'h2 : 32'h0, 32'(s_axi_rresp));
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wait_lock(input logic v);
    int n = 0;
    while (lock_n !== v && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    check(32'(v), 32'(lock_n));
  endtask
  task automatic run(input int n, input string s);
    sync_b <= 1'h0;
    repeat (n) @(posedge aclk);
    // Pause data so the buffer holds only sync words
    sync_b <= 1'h1;
    repeat (240) @(posedge aclk);
    check(32'h0, 32'(exp_q.size()));
    $display("done %s", s);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h00, 32'h2, 32'hFFFFFFFF);
    check(32'h0, 32'(lock_n_oe | parallel_word_out_oe));
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    wr(8'h44, 32'h1, 2'h2);
    sync_b <= 1'h1;
    mon_on <= 1'h1;
    wr(8'h00, 32'h5, 2'h0);
    wait_lock(1'h0);
    rd(8'h04, 32'h1, 32'h1);
    run(600, "rising");
    wr(8'h00, 32'h1, 2'h0);
    edge_sel <= 1'h0;
    run(600, "falling");
    wr(8'h00, 32'h3, 2'h0);
    check(32'h0, 32'(lock_n_oe | recovered_clock_oe));
    repeat (200) @(posedge aclk);
    rd(8'h04, 32'h7, 32'h7);
    wr(8'h00, 32'h1, 2'h0);
    run(300, "buffer");
    mon_on <= 1'h0;
    corrupt <= 1'h1;
    repeat (24) @(posedge aclk);
    corrupt <= 1'h0;
    repeat (30) @(posedge aclk);
    check(32'h0, 32'(lock_n));
    corrupt <= 1'h1;
    repeat (72) @(posedge aclk);
    check(32'h1, 32'(lock_n));
    check(32'h2, 32'({lock_n_oe, parallel_word_out_oe}));
    rd(8'h04, 32'h8, 32'h8);
    corrupt <= 1'h0;
    wait_lock(1'h0);
    wr(8'h00, 32'h0, 2'h0);
    check(32'h0, 32'(lock_n_oe | recovered_clock_oe));
    $display("done loss");
    end_of_test();
  end
endmodule
`default_nettype wire
